// ==== core/bpa_pkg.sv ====
// bpa_pkg: shared constants and carrier types for the backplane arbiter
// assumes a single 200 MHz clock domain; bus pins already synchronous
`default_nettype none
package bpa_pkg;
    // =====================================================================
    // timing
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned HALT_MIN_NS    = 25000;
    // least time rounds up to whole cycles
    localparam int unsigned HALT_CYCLES    = (HALT_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
    localparam int unsigned HALT_CNT_W     = 13;
    localparam int unsigned REF_MAX_US     = 1600;
    localparam int unsigned REF_CYCLES     = (REF_MAX_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned REF_CNT_W      = 19;

    // =====================================================================
    // arbiter states, one-hot
    typedef enum logic [3:0] {
        BPA_CPU    = 4'b0001,
        BPA_WAIT   = 4'b0010,
        BPA_GRANT  = 4'b0100,
        BPA_DMA    = 4'b1000
    } bpa_arb_type;

    // =====================================================================
    // backplane handshake lines seen by the block (active low)
    typedef struct packed {
        logic dma_request_n;
        logic select_ack_n;
        logic bus_sync_n;
        logic data_in_strobe_n;
        logic halt_request_n;
        logic refresh_n;
    } bpa_bus_in_type;

    // processor-side status
    typedef struct packed {
        logic halted;
        logic console_debug_microcode;
        logic refresh_strobe;
        logic block_mode;
        logic refresh_late;
    } bpa_stat_type;
endpackage : bpa_pkg
`default_nettype wire

// ==== core/bpa_halt_filter.sv ====
// bpa_halt_filter: qualifies the halt request by a minimum assert time
// assumes input already synchronous to i_clk
`default_nettype none
module bpa_halt_filter (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_halt_request_n,
    output logic      o_halt_seen
);
    logic [bpa_pkg::HALT_CNT_W-1:0] cnt_r;
    logic [bpa_pkg::HALT_CNT_W-1:0] cnt_nxt;
    logic                           seen_r;
    logic                           seen_nxt;

    // =====================================================================
    // count how long the request has stood; a short glitch restarts
    always_comb begin
        cnt_nxt  = cnt_r;
        seen_nxt = 1'b0;
        if (i_halt_request_n) begin
            cnt_nxt = '0;
        end else if (cnt_r != bpa_pkg::HALT_CNT_W'(bpa_pkg::HALT_CYCLES - 1)) begin
            cnt_nxt = cnt_r + 1'b1;
        end else begin
            seen_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r  <= '0;
            seen_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign o_halt_seen = seen_r;
endmodule : bpa_halt_filter
`default_nettype wire

// ==== core/bpa_arbiter.sv ====
// bpa_arbiter: bus mastership arbiter, halt handling and refresh watch
// assumes all bus inputs are synchronous to i_clk and already inverted
// nowhere; the processor core reports its own sync strobe on i_cpu_sync
//
// Operation
// - processor arbitrates between itself and modules
// - grant only when processor not bus master
// - grant signalled by driving grant line low
// - halt held 25 us stops execution
// - halted: ignore interrupts, dma optionally enabled
// - halted processor runs console debug microcode
// - refresh line also marks block mode
// - spare line shows processor run state
`default_nettype none
module bpa_arbiter (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire bpa_pkg::bpa_bus_in_type i_bus,
    input  wire logic                    i_cpu_sync,
    input  wire logic                    i_cpu_want_bus,
    input  wire logic                    i_irq_pending,
    input  wire logic                    i_halt_dma_enable,
    input  wire logic                    i_continue,
    output logic                         o_dma_grant_out_n,
    output logic                         o_cpu_may_drive,
    output logic                         o_irq_take,
    output logic                         o_refresh_take,
    output logic                         o_run_indicator,
    output bpa_pkg::bpa_stat_type        o_stat
);
    bpa_pkg::bpa_arb_type              arb_r;
    bpa_pkg::bpa_arb_type              arb_nxt;
    logic                              halted_r;
    logic                              halted_nxt;
    logic                              grant_n_r;
    logic                              grant_n_nxt;
    logic                              run_r;
    logic                              run_nxt;
    logic                              dstb_r;
    logic                              dstb_nxt;
    logic                              rstb_r;
    logic                              rstb_nxt;
    logic                              late_r;
    logic                              late_nxt;
    logic [bpa_pkg::REF_CNT_W-1:0]     rcnt_r;
    logic [bpa_pkg::REF_CNT_W-1:0]     rcnt_nxt;
    logic                              halt_seen;
    logic                              dma_allowed;
    logic                              xfer_edge;

    // =====================================================================
    // halt qualification
    // the filter sits in its own module so its long counter stays apart
    bpa_halt_filter u_halt (
        .i_clk            (i_clk),
        .i_rst            (i_rst),
        .i_halt_request_n (i_bus.halt_request_n),
        .o_halt_seen      (halt_seen)
    );

    // dma serviced while running, or while halted if the board option allows
    // the option input is a board strap; it is read every cycle, not latched
    // halt gates dma
    assign dma_allowed = !halted_r || i_halt_dma_enable;

    // =====================================================================
    // arbiter and halt state
    // idle -> wait: a request is pending, the processor finishes its cycle
    // wait -> grant: sync released, grant line driven low
    // grant -> dma: the module answers with select acknowledge
    // dma -> idle: acknowledge released, grant withdrawn in the same edge
    // the grant is a registered level so the module never sees a glitch on
    // it; the price is one extra cycle of latency after sync is released
    always_comb begin
        arb_nxt     = arb_r;
        grant_n_nxt = grant_n_r;
        halted_nxt  = halted_r;
        if (halt_seen) begin
            halted_nxt = 1'b1;
        end else if (halted_r && i_continue && i_bus.halt_request_n) begin
            halted_nxt = 1'b0;
        end
        case (arb_r)
            bpa_pkg::BPA_CPU: begin
                if (!i_bus.dma_request_n && dma_allowed) begin
                    arb_nxt = bpa_pkg::BPA_WAIT;
                end
            end
            bpa_pkg::BPA_WAIT: begin
                // wait end of cycle
                // a withdrawn request or a halt without the board option both
                // fall back to idle, so no grant escapes once halted
                if (i_bus.dma_request_n) begin
                    arb_nxt = bpa_pkg::BPA_CPU;
                end else if (!dma_allowed) begin
                    arb_nxt = bpa_pkg::BPA_CPU;
                end else if (!i_cpu_sync) begin
                    arb_nxt     = bpa_pkg::BPA_GRANT;
                    grant_n_nxt = 1'b0;
                end
            end
            bpa_pkg::BPA_GRANT: begin
                if (!i_bus.select_ack_n) begin
                    arb_nxt = bpa_pkg::BPA_DMA;
                end
            end
            bpa_pkg::BPA_DMA: begin
                // grant stays low for the whole tenure; dropping it early would
                // let the processor collide with the module on the bus
                // release on ack
                if (i_bus.select_ack_n) begin
                    arb_nxt     = bpa_pkg::BPA_CPU;
                    grant_n_nxt = 1'b1;
                end
            end
            default: begin
                arb_nxt     = bpa_pkg::BPA_CPU;
                grant_n_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            arb_r     <= bpa_pkg::BPA_CPU;
            grant_n_r <= 1'b1;
            halted_r  <= 1'b0;
        end else begin
            arb_r     <= arb_nxt;
            grant_n_r <= grant_n_nxt;
            halted_r  <= halted_nxt;
        end
    end

    // =====================================================================
    // refresh and block-mode watch
    // memories refresh themselves off the bus strobes; this block only
    // watches them so the processor can see each refresh and a late one
    // limitation: the watchdog cannot tell which master starved refresh
    // a refresh transfer is the data-in strobe falling under sync with refresh low
    assign xfer_edge = !i_bus.bus_sync_n && !i_bus.data_in_strobe_n && !dstb_r;

    always_comb begin
        dstb_nxt = !i_bus.bus_sync_n && !i_bus.data_in_strobe_n;
        rstb_nxt = 1'b0;
        late_nxt = late_r;
        rcnt_nxt = rcnt_r;
        if (xfer_edge && !i_bus.refresh_n) begin
            rstb_nxt = 1'b1;
            rcnt_nxt = '0;
        end else if (rcnt_r != bpa_pkg::REF_CNT_W'(bpa_pkg::REF_CYCLES)) begin
            rcnt_nxt = rcnt_r + 1'b1;
        end else begin
            // overdue refresh flag; sticky, cleared only by reset
            late_nxt = 1'b1;
        end
        // one master hogging past the window also shows as late
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dstb_r <= 1'b0;
            rstb_r <= 1'b0;
            late_r <= 1'b0;
            rcnt_r <= '0;
        end else begin
            dstb_r <= dstb_nxt;
            rstb_r <= rstb_nxt;
            late_r <= late_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end

    // =====================================================================
    // run indicator on the spare line
    // registered so the spare line never glitches while halt is decided;
    // it follows the halt flag at the same edge
    always_comb begin
        run_nxt = !halted_nxt;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
        end
    end

    // =====================================================================
    // outputs
    assign o_dma_grant_out_n = grant_n_r;
    // processor owns the bus only with no grant outstanding and not halted
    assign o_cpu_may_drive   = (arb_r == bpa_pkg::BPA_CPU) && !halted_r && i_cpu_want_bus;
    assign o_irq_take        = i_irq_pending && !halted_r;
    // refresh seen by the processor only while dma is allowed
    assign o_refresh_take    = rstb_r && dma_allowed;
    assign o_run_indicator   = run_r;
    assign o_stat.halted                  = halted_r;
    assign o_stat.console_debug_microcode = halted_r;
    assign o_stat.refresh_strobe          = rstb_r;
    // combinational so the marker follows the refresh line at once
    // block mode marker
    assign o_stat.block_mode              = (arb_r == bpa_pkg::BPA_DMA) && !i_bus.refresh_n;
    assign o_stat.refresh_late            = late_r;
endmodule : bpa_arbiter
`default_nettype wire

// ==== test/bpa_arbiter_monitor.sv ====
// bpa_arbiter_monitor: port-level checks on the backplane arbiter
// assumes one clock domain and the port set of bpa_arbiter
`default_nettype none
module bpa_arbiter_monitor (
    input wire logic                    i_clk,
    input wire logic                    i_rst,
    input wire bpa_pkg::bpa_bus_in_type i_bus,
    input wire logic                    i_cpu_sync,
    input wire logic                    i_irq_pending,
    input wire logic                    o_dma_grant_out_n,
    input wire logic                    o_cpu_may_drive,
    input wire logic                    o_irq_take,
    input wire logic                    o_run_indicator,
    input wire bpa_pkg::bpa_stat_type   o_stat
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // =====================================================================
    // consecutive halt-low cycles, saturating so long halts never wrap
    logic [15:0] lo_r;
    logic [15:0] lo_nxt;
    always_comb lo_nxt = i_bus.halt_request_n ? 16'h0000 : lo_r + {15'h0000, ~&lo_r};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) lo_r <= 16'h0000;
        else lo_r <= lo_nxt;
    end
    // =====================================================================
    AST_GRANT_REQ: assert property ($fell(o_dma_grant_out_n) |-> !$past(i_bus.dma_request_n))
        else $error("grant without request");
    AST_GRANT_IDLE: assert property ($fell(o_dma_grant_out_n) |-> !$past(i_cpu_sync))
        else $error("grant while processor is master");
    AST_CPU_OFF: assert property (o_cpu_may_drive |-> o_dma_grant_out_n)
        else $error("processor drives during grant");
    AST_GRANT_KEEP: assert property (!o_dma_grant_out_n && !i_bus.select_ack_n
        |=> !o_dma_grant_out_n)
        else $error("grant dropped under acknowledge");
    AST_GRANT_END: assert property ($rose(o_dma_grant_out_n) |-> $past(i_bus.select_ack_n))
        else $error("grant ended before release");
    AST_HALT_MIN: assert property ($rose(o_stat.halted) |-> lo_r >= 16'(bpa_pkg::HALT_CYCLES))
        else $error("halt taken too soon");
    AST_IRQ_MASK: assert property (o_irq_take == (i_irq_pending && !o_stat.halted))
        else $error("interrupt take wrong");
    AST_CONSOLE: assert property (o_stat.halted |-> o_stat.console_debug_microcode)
        else $error("no console microcode when halted");
    AST_RUN_OFF: assert property (o_stat.halted ##1 o_stat.halted |-> !o_run_indicator)
        else $error("run shown while halted");
    AST_REF_PULSE: assert property ($rose(o_stat.refresh_strobe)
        |-> !$past(i_bus.refresh_n) ##1 !o_stat.refresh_strobe)
        else $error("refresh strobe wrong");
    AST_BLOCK: assert property (o_stat.block_mode |-> !i_bus.refresh_n)
        else $error("block mode without refresh line");
    COV_GRANT: cover property ($fell(o_dma_grant_out_n));
    COV_HALT: cover property ($rose(o_stat.halted));
    COV_REF: cover property ($rose(o_stat.refresh_strobe));
endmodule : bpa_arbiter_monitor
bind bpa_arbiter bpa_arbiter_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus),
    .i_cpu_sync(i_cpu_sync), .i_irq_pending(i_irq_pending),
    .o_dma_grant_out_n(o_dma_grant_out_n), .o_cpu_may_drive(o_cpu_may_drive),
    .o_irq_take(o_irq_take), .o_run_indicator(o_run_indicator), .o_stat(o_stat));
`default_nettype wire

// ==== test/bpa_dma_model.sv ====
// bpa_dma_model: one dma-capable option module on the backplane
// assumes grant is a registered level; drives 1 ns after each edge
`default_nettype none
module bpa_dma_model (
    input  wire logic i_clk,
    input  wire logic i_go,
    input  wire logic i_ref,
    input  wire logic i_grant_n,
    output logic      o_req_n,
    output logic      o_ack_n,
    output logic      o_ref_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold;
    initial begin
        o_req_n = 1'b1;
        o_ack_n = 1'b1;
        o_ref_n = 1'b1;
        hold = 0;
    end
    // =====================================================================
    // single transfer per tenure, so refresh is never held off by bursts
    always @(posedge i_clk) begin
        #1;
        if (hold > 0) begin
            hold--;
            if (hold == 0) begin
                o_ack_n = 1'b1;
                o_ref_n = 1'b1;
            end
        end else if (!o_req_n && !i_grant_n) begin
            o_req_n = 1'b1;
            o_ack_n = 1'b0;
            o_ref_n = !i_ref;
            hold = 4;
        end else o_req_n = !i_go;
    end
endmodule : bpa_dma_model
`default_nettype wire

// ==== test/testbench.sv ====
// testbench: directed scenarios for the backplane arbiter
// assumes bpa_dma_model on the far side; bench drives 2 ns after edges
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, sync = 1'b0, want = 1'b1, irq = 1'b0, cont = 1'b0;
    logic go = 1'b0, ref_on = 1'b0, sync_n = 1'b1, din_n = 1'b1, halt_n = 1'b1, hde = 1'b0;
    logic req_n, ack_n, ref_n, gnt_n, may, irq_t, rfr, run;
    bpa_pkg::bpa_stat_type st;
    int num_errors = 0, total_checks = 0, n;
    always #2.5 clk = ~clk;
    bpa_dma_model u_dma (.i_clk(clk), .i_go(go), .i_ref(ref_on), .i_grant_n(gnt_n),
        .o_req_n(req_n), .o_ack_n(ack_n), .o_ref_n(ref_n));
    bpa_arbiter dut (.i_clk(clk), .i_rst(rst),
        .i_bus({req_n, ack_n, sync_n, din_n, halt_n, ref_n}), .i_cpu_sync(sync),
        .i_cpu_want_bus(want), .i_irq_pending(irq), .i_halt_dma_enable(hde),
        .i_continue(cont), .o_dma_grant_out_n(gnt_n), .o_cpu_may_drive(may),
        .o_irq_take(irq_t), .o_refresh_take(rfr), .o_run_indicator(run), .o_stat(st));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : cyc
    task automatic close_out;
        if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // wait for the grant line to reach a level, bounded
    task automatic wgnt(input logic lvl);
        for (n = 0; n < 8 && gnt_n !== lvl; n++) cyc(1);
        if (gnt_n !== lvl) begin
            chk("grant wait", 16'h0000, 16'h0001);
            close_out();
        end
    endtask : wgnt
    // =====================================================================
    // request dropped while processor still owns a cycle: no grant
    task automatic t_abort;
        sync = 1'b1;
        go = 1'b1;
        cyc(4);
        go = 1'b0;
        cyc(2);
        sync = 1'b0;
        cyc(4);
        chk("abort grant", 16'(gnt_n), 16'h0001);
    endtask : t_abort
    // =====================================================================
    // full tenure with one refresh transfer in block mode
    task automatic t_grant;
        sync = 1'b1;
        go = 1'b1;
        ref_on = 1'b1;
        cyc(6);
        chk("grant held off", 16'(gnt_n), 16'h0001);
        sync = 1'b0;
        wgnt(1'b0);
        chk("ack", 16'(ack_n), 16'h0000);
        go = 1'b0;
        sync_n = 1'b0;
        din_n = 1'b0;
        cyc(1);
        chk("block mode", 16'(st.block_mode), 16'h0001);
        chk("cpu off bus", 16'(may), 16'h0000);
        sync_n = 1'b1;
        din_n = 1'b1;
        for (n = 0; n < 4 && st.refresh_strobe !== 1'b1; n++) cyc(1);
        chk("refresh strobe", 16'(st.refresh_strobe), 16'h0001);
        if (st.refresh_strobe !== 1'b1) close_out();
        chk("refresh take", 16'(rfr), 16'h0001);
        cyc(1);
        chk("strobe width", 16'(st.refresh_strobe), 16'h0000);
        wgnt(1'b1);
        chk("ack at release", 16'(ack_n), 16'h0001);
        cyc(1);
        chk("cpu back", 16'(may), 16'h0001);
        ref_on = 1'b0;
        want = 1'b0;
        cyc(1);
        chk("cpu idle", 16'(may), 16'h0000);
        want = 1'b1;
    endtask : t_grant
    // =====================================================================
    // short halt refused, long halt taken, requests ignored, then resume
    task automatic t_halt;
        irq = 1'b1;
        cyc(1);
        chk("irq run", 16'(irq_t), 16'h0001);
        halt_n = 1'b0;
        cyc(4000);
        chk("short halt", 16'(st.halted), 16'h0000);
        halt_n = 1'b1;
        cyc(2);
        halt_n = 1'b0;
        for (n = 1; n < 5010 && st.halted !== 1'b1; n++) cyc(1);
        chk("halt taken", 16'(st.halted), 16'h0001);
        if (st.halted !== 1'b1) close_out();
        chk("halt time ok", 16'(n >= int'(bpa_pkg::HALT_CYCLES)), 16'h0001);
        chk("halt time late", 16'(n <= int'(bpa_pkg::HALT_CYCLES) + 2), 16'h0001);
        chk("irq halted", 16'(irq_t), 16'h0000);
        chk("console", 16'(st.console_debug_microcode), 16'h0001);
        cyc(1);
        chk("run off", 16'(run), 16'h0000);
        go = 1'b1;
        cyc(8);
        chk("no grant halted", 16'(gnt_n), 16'h0001);
        // board option on: the held request is served while halted
        hde = 1'b1;
        ref_on = 1'b1;
        wgnt(1'b0);
        go = 1'b0;
        sync_n = 1'b0;
        din_n = 1'b0;
        cyc(1);
        chk("halted refresh", 16'(st.refresh_strobe), 16'h0001);
        chk("halted refresh take", 16'(rfr), 16'h0001);
        sync_n = 1'b1;
        din_n = 1'b1;
        wgnt(1'b1);
        chk("halted ack off", 16'(ack_n), 16'h0001);
        hde = 1'b0;
        ref_on = 1'b0;
        halt_n = 1'b1;
        cont = 1'b1;
        cyc(3);
        cont = 1'b0;
        cyc(2);
        chk("resumed", 16'(st.halted), 16'h0000);
        chk("run on", 16'(run), 16'h0001);
        chk("no late refresh", 16'(st.refresh_late), 16'h0000);
    endtask : t_halt
    initial begin
        cyc(5);
        rst = 1'b0;
        cyc(2);
        chk("grant idle", 16'(gnt_n), 16'h0001);
        t_abort();
        t_grant();
        t_halt();
        close_out();
    end
endmodule : testbench
`default_nettype wire
